// ### shared/dur_map.svh
`ifndef DUR_MAP_SVH
`define DUR_MAP_SVH
// Channel count and address layout
`define DUR_NUM_CH 2
`define DUR_CH_BIT 7
`define DUR_ADDR_W 8
// Register word index; byte address is index * 4, plus 0x80 for channel B
`define DUR_IDX_RXHOLD 5'h00
`define DUR_IDX_TXHOLD 5'h01
`define DUR_IDX_INTEN 5'h02
`define DUR_IDX_FIFOCTRL 5'h03
`define DUR_IDX_INTSTAT 5'h04
`define DUR_IDX_LINECTRL 5'h05
`define DUR_IDX_MODEMCTRL 5'h06
`define DUR_IDX_LINESTAT 5'h07
`define DUR_IDX_MODEMSTAT 5'h08
`define DUR_IDX_SCRATCH 5'h09
`define DUR_IDX_DIVLOW 5'h0a
`define DUR_IDX_DIVHIGH 5'h0b
`define DUR_IDX_FRACDIV 5'h0c
`define DUR_IDX_MODESEL 5'h0d
`define DUR_IDX_FIFOLVL 5'h0e
`define DUR_IDX_ENHFEAT 5'h0f
`define DUR_IDX_RESUME1 5'h10
`define DUR_IDX_RESUME2 5'h11
`define DUR_IDX_PAUSE1 5'h12
`define DUR_IDX_PAUSE2 5'h13
`define DUR_IDX_TRIGLVL 5'h14
// Reset values
`define DUR_RST_ZERO 8'h00
`define DUR_RST_DIVHIGH 8'h00
`define DUR_RST_DIVLOW 8'h01
`define DUR_RST_INTSTAT 8'h01
`define DUR_RST_LINESTAT 8'h60
`define DUR_RST_SCRATCH 8'hff
`define DUR_RST_MODESEL 8'h80
`define DUR_RST_MODEMLAST 4'hf
// Field positions
`define DUR_EFR_ENH_BIT 4
`define DUR_LCR_BREAK_BIT 6
`define DUR_MCR_DTR_BIT 0
`define DUR_MCR_RTS_BIT 1
`define DUR_MCR_OP2_BIT 3
`define DUR_IER_MODEM_BIT 3
`define DUR_FCR_EN_BIT 0
`endif

// ### shared/dur_pkg.sv
`include "dur_map.svh"
package dur_pkg;
  // Register set of one channel
  typedef struct packed {
    logic [7:0] divHigh;
    logic [7:0] divLow;
    logic [7:0] fracDiv;
    logic [7:0] rxHold;
    logic [7:0] txHold;
    logic [7:0] intEnable;
    logic [7:0] fifoCtrl;
    logic [7:0] lineCtrl;
    logic [7:0] modemCtrl;
    logic [7:0] scratch;
    logic [7:0] modeSel;
    logic [7:0] fifoLevel;
    logic [7:0] enhFeature;
    logic [7:0] resume1;
    logic [7:0] resume2;
    logic [7:0] pause1;
    logic [7:0] pause2;
    logic [7:0] trigLevel;
    logic [3:0] modemDelta;
    logic [3:0] modemLast;
  } dur_chan_t;
  // Output pins of one channel, active-low pins end in N
  typedef struct packed {
    logic txOut;
    logic generalOutputTwoN;
    logic rtsN;
    logic dtrN;
    logic receiveReadyN;
    logic transmitReadyN;
    logic irqOut;
    logic irqOe;
  } dur_pins_t;
  // Modem input pins of one channel, all active low
  typedef struct packed {
    logic cdN;
    logic riN;
    logic dsrN;
    logic ctsN;
  } dur_modem_t;
  // Whole state of the block
  typedef struct packed {
    dur_chan_t [`DUR_NUM_CH-1:0] ch;
    dur_pins_t [`DUR_NUM_CH-1:0] pins;
    logic ack;
    logic [7:0] rdata;
  } dur_state_t;
endpackage

// ### src/dur_reset_regs.sv
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dur_map.svh"

module dur_reset_regs
  import dur_pkg::*;
(
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic reset, // Power-up reset, async, active high
  input wire logic pinReset, // Hardware reset pin, active high
  input wire logic [`DUR_ADDR_W-1:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data, low byte used
  input wire logic [3:0] avs_byteenable, // Byte lanes, lane 0 used
  output logic [31:0] avs_readdata, // Read data, low byte
  output logic avs_waitrequest, // Stall while answer pending
  input wire dur_modem_t [`DUR_NUM_CH-1:0] modemIn, // Modem inputs
  output dur_pins_t [`DUR_NUM_CH-1:0] pinsOut // Serial and status pins
);

  // Whole state and its next value
  // Two reset sources share these flops:
  // the power-up reset is asynchronous and loads every field,
  // the reset pin is sampled and spares the divisor bytes.
  // Keeping both in one struct keeps one clocked process.
  dur_state_t state_reg;
  dur_state_t state_next;

  // Request decode
  logic busReq; // Request waiting for its answer
  logic chanSel; // Channel addressed
  logic [4:0] regIdx; // Register index addressed
  logic laneOk; // Low byte lane enabled

  // Channel register set as seen after power-up
  // Only constants here, so the async branch stays glitch free
  // Holding registers start at zero, software must not rely on it
  // Modem reference assumes idle inputs, all high
  function automatic dur_chan_t powerUpChan();
    dur_chan_t r;
    r = '0;
    r.divHigh = `DUR_RST_DIVHIGH;
    r.divLow = `DUR_RST_DIVLOW;
    r.scratch = `DUR_RST_SCRATCH;
    r.modeSel = `DUR_RST_MODESEL;
    r.modemLast = `DUR_RST_MODEMLAST;
    return r;
  endfunction

  // Reset values for the pin reset
  // Applied on every edge while the pin is high
  // Divisor survives so the baud rate holds across a pin reset
  // Holding registers are left alone, their content is not promised
  function automatic dur_chan_t pinResetChan(dur_chan_t c, dur_modem_t m);
    dur_chan_t r;
    r = c;
    // Divisor bytes are not touched here
    r.divHigh = c.divHigh;
    r.divLow = c.divLow;
    // Holding registers keep whatever they held
    r.rxHold = c.rxHold;
    r.txHold = c.txHold;
    r.fracDiv = `DUR_RST_ZERO;
    r.intEnable = `DUR_RST_ZERO;
    r.fifoCtrl = `DUR_RST_ZERO;
    r.lineCtrl = `DUR_RST_ZERO;
    r.modemCtrl = `DUR_RST_ZERO;
    r.scratch = `DUR_RST_SCRATCH;
    r.modeSel = `DUR_RST_MODESEL;
    r.fifoLevel = `DUR_RST_ZERO;
    r.trigLevel = `DUR_RST_ZERO;
    r.enhFeature = `DUR_RST_ZERO;
    r.resume1 = `DUR_RST_ZERO;
    r.resume2 = `DUR_RST_ZERO;
    r.pause1 = `DUR_RST_ZERO;
    r.pause2 = `DUR_RST_ZERO;
    // Change bits clear, current inputs become the reference
    r.modemDelta = 4'h0;
    r.modemLast = m;
    return r;
  endfunction

  // Modem status interrupt pending
  // Only the modem source exists in this block
  // Reset clears the enable, so nothing is pending after reset
  function automatic logic irqPending(dur_chan_t c);
    return c.intEnable[`DUR_IER_MODEM_BIT] & (|c.modemDelta);
  endfunction

  // Interrupt status as read
  function automatic logic [7:0] intStatus(dur_chan_t c);
    logic [7:0] v;
    v = `DUR_RST_INTSTAT;
    // Modem status source reports code 0x00
    if (irqPending(c)) begin
      v = `DUR_RST_ZERO;
    end
    // Top two bits mirror the FIFO enable
    v[7] = c.fifoCtrl[`DUR_FCR_EN_BIT];
    v[6] = c.fifoCtrl[`DUR_FCR_EN_BIT];
    return v;
  endfunction

  // Register read multiplexer
  // Purely combinational; the caller registers the result
  // Line status is fixed, no transmitter or receiver here
  // Modem status upper nibble is live, not a stored copy
  function automatic logic [7:0] readReg(dur_chan_t c, logic [4:0] idx, dur_modem_t m);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `DUR_IDX_RXHOLD: begin
        v = c.rxHold;
      end
      `DUR_IDX_INTEN: begin
        v = c.intEnable;
      end
      `DUR_IDX_INTSTAT: begin
        v = intStatus(c);
      end
      `DUR_IDX_LINECTRL: begin
        v = c.lineCtrl;
      end
      `DUR_IDX_MODEMCTRL: begin
        v = c.modemCtrl;
      end
      `DUR_IDX_LINESTAT: begin
        // Transmitter idle and empty, nothing received
        v = `DUR_RST_LINESTAT;
      end
      `DUR_IDX_MODEMSTAT: begin
        // Live inputs inverted above the change bits
        v = {~m, c.modemDelta};
      end
      `DUR_IDX_SCRATCH: begin
        v = c.scratch;
      end
      `DUR_IDX_DIVLOW: begin
        v = c.divLow;
      end
      `DUR_IDX_DIVHIGH: begin
        v = c.divHigh;
      end
      `DUR_IDX_FRACDIV: begin
        v = c.fracDiv;
      end
      `DUR_IDX_FIFOLVL: begin
        v = c.fifoLevel;
      end
      `DUR_IDX_ENHFEAT: begin
        v = c.enhFeature;
      end
      `DUR_IDX_RESUME1: begin
        v = c.resume1;
      end
      `DUR_IDX_RESUME2: begin
        v = c.resume2;
      end
      `DUR_IDX_PAUSE1: begin
        v = c.pause1;
      end
      `DUR_IDX_PAUSE2: begin
        v = c.pause2;
      end
      `DUR_IDX_TRIGLVL: begin
        v = c.trigLevel;
      end
      // Write-only and unmapped words read zero
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // Register write; enhanced bits change only while unlocked
  // Locked fields keep their stored value so legacy code cannot alter them
  // Unlock is the enhanced enable bit of the feature register
  function automatic dur_chan_t writeReg(dur_chan_t c, logic [4:0] idx, logic [7:0] d);
    dur_chan_t r;
    logic unlocked;
    r = c;
    unlocked = c.enhFeature[`DUR_EFR_ENH_BIT];
    case (idx)
      `DUR_IDX_TXHOLD: begin
        r.txHold = d;
      end
      `DUR_IDX_INTEN: begin
        // Upper nibble is an enhanced field
        r.intEnable = unlocked ? d : {c.intEnable[7:4], d[3:0]};
      end
      `DUR_IDX_FIFOCTRL: begin
        // Bits 5 and 4 are enhanced fields
        r.fifoCtrl = unlocked ? d : {d[7:6], c.fifoCtrl[5:4], d[3:0]};
      end
      `DUR_IDX_LINECTRL: begin
        r.lineCtrl = d;
      end
      `DUR_IDX_MODEMCTRL: begin
        // Bits 7 to 5 are enhanced fields
        r.modemCtrl = unlocked ? d : {c.modemCtrl[7:5], d[4:0]};
      end
      `DUR_IDX_SCRATCH: begin
        r.scratch = d;
      end
      `DUR_IDX_DIVLOW: begin
        r.divLow = d;
      end
      `DUR_IDX_DIVHIGH: begin
        r.divHigh = d;
      end
      `DUR_IDX_FRACDIV: begin
        // Locked unless enhanced writes are on
        if (unlocked) begin
          r.fracDiv = d;
        end
      end
      `DUR_IDX_MODESEL: begin
        r.modeSel = d;
      end
      `DUR_IDX_ENHFEAT: begin
        r.enhFeature = d;
      end
      `DUR_IDX_RESUME1: begin
        r.resume1 = d;
      end
      `DUR_IDX_RESUME2: begin
        r.resume2 = d;
      end
      `DUR_IDX_PAUSE1: begin
        r.pause1 = d;
      end
      `DUR_IDX_PAUSE2: begin
        r.pause2 = d;
      end
      `DUR_IDX_TRIGLVL: begin
        r.trigLevel = d;
      end
      // Read-only and unmapped words ignore writes
      default: begin
        r = c;
      end
    endcase
    return r;
  endfunction

  // Pin levels derived from a channel's registers
  // Cleared line and modem control give the reset pin levels
  // Result is registered from the next register values, so pins change on the same edge as the registers
  function automatic dur_pins_t pinsOf(dur_chan_t c);
    dur_pins_t p;
    // Line idles high unless break is forced
    p.txOut = ~c.lineCtrl[`DUR_LCR_BREAK_BIT];
    p.generalOutputTwoN = ~c.modemCtrl[`DUR_MCR_OP2_BIT];
    p.rtsN = ~c.modemCtrl[`DUR_MCR_RTS_BIT];
    p.dtrN = ~c.modemCtrl[`DUR_MCR_DTR_BIT];
    // Nothing received, transmitter always ready
    p.receiveReadyN = 1'b1;
    p.transmitReadyN = 1'b0;
    // Interrupt pin driven only while OP2 is set
    p.irqOe = c.modemCtrl[`DUR_MCR_OP2_BIT];
    p.irqOut = irqPending(c);
    return p;
  endfunction

  // Bus decode
  // Ack alternates with the request, giving exactly one wait cycle while the reset pin is low
  // Address bits 1:0 are ignored, registers sit on word boundaries
  assign busReq = (avs_read | avs_write) & ~state_reg.ack;
  assign chanSel = avs_address[`DUR_CH_BIT];
  assign regIdx = avs_address[6:2];
  assign laneOk = avs_byteenable[0];

  // Next-state logic
  // Order matters: modem tracking, then bus write, then pin reset
  // The pin reset comes last so it beats a write in the same cycle
  always_comb begin
    state_next = state_reg;
    // One wait cycle, then the answer
    state_next.ack = busReq;
    // Read data captured on the first cycle
    if (busReq && avs_read) begin
      state_next.rdata = readReg(state_reg.ch[chanSel], regIdx, modemIn[chanSel]);
    end
    // Same logic for every channel
    for (int i = 0; i < `DUR_NUM_CH; i++) begin
      // Change bits: a new change wins over a read clear
      if (busReq && avs_read && (chanSel == i[0]) &&
          (regIdx == `DUR_IDX_MODEMSTAT)) begin
        state_next.ch[i].modemDelta = 4'h0;
      end
      state_next.ch[i].modemDelta = state_next.ch[i].modemDelta |
                                    (modemIn[i] ^ state_reg.ch[i].modemLast);
      state_next.ch[i].modemLast = modemIn[i];
      // Write lands on the cycle waitrequest is low
      if (state_reg.ack && avs_write && laneOk && (chanSel == i[0])) begin
        state_next.ch[i] = writeReg(state_next.ch[i], regIdx, avs_writedata[7:0]);
      end
      // Pin reset overrides everything except the divisor and the holding registers
      if (pinReset) begin
        state_next.ch[i] = pinResetChan(state_reg.ch[i], modemIn[i]);
      end
      // Pins follow the next register values
      state_next.pins[i] = pinsOf(state_next.ch[i]);
    end
    // Pending bus answer is dropped by the pin reset
    if (pinReset) begin
      state_next.ack = 1'b0;
    end
  end

  // State register; power-up reset loads every field
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_reg.ack <= 1'b0;
      state_reg.rdata <= 8'h00;
      for (int i = 0; i < `DUR_NUM_CH; i++) begin
        state_reg.ch[i] <= powerUpChan();
        // Outputs idle, interrupt pin floating
        state_reg.pins[i] <= '{txOut: 1'b1, generalOutputTwoN: 1'b1,
                              rtsN: 1'b1, dtrN: 1'b1, receiveReadyN: 1'b1,
                              transmitReadyN: 1'b0, irqOut: 1'b0,
                              irqOe: 1'b0};
      end
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus outputs
  // Stall is combinational; read data comes from a flop
  // Read data stands until the next read is captured
  assign avs_waitrequest = busReq;
  assign avs_readdata = {24'h00_0000, state_reg.rdata};

  // Pin outputs, one per channel
  // Straight from flops, no logic after the register
  genvar g;
  generate
    for (g = 0; g < `DUR_NUM_CH; g++) begin : gPins
      assign pinsOut[g] = state_reg.pins[g];
    end
  endgenerate

endmodule
`default_nettype wire

// ### verif/dur_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dur_host (
  input wire logic clk_sys, // Clock
  output logic [7:0] avs_address, // Byte address
  output logic avs_read, // Read
  output logic avs_write, // Write
  output logic [31:0] avs_writedata, // Write data
  output logic [3:0] avs_byteenable, // Lanes
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest // Stall
);
  // Idle bus at start
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end
  // One bus cycle, held until the stall drops
  task automatic xfer(input logic wr, input logic [7:0] adr, input logic [7:0] d,
    input logic be, output logic [7:0] q);
    logic hit;
    avs_address <= adr;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= {3'h0, be};
    hit = 1'b0;
    // Stall and data are settled by the falling edge, so no race with the flops
    while (!hit) begin
      @(negedge clk_sys);
      hit = !avs_waitrequest;
      q = avs_readdata[7:0];
      @(posedge clk_sys);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines show no stale value
    avs_address <= ~adr;
    avs_writedata <= ~{24'h00_0000, d};
    @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// ### verif/dur_reset_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "dur_map.svh"
module dur_reset_props
  import dur_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset, // Power-up reset
  input wire logic pinReset, // Reset pin
  input wire logic [`DUR_ADDR_W-1:0] avs_address, // Address
  input wire logic avs_read, // Read
  input wire logic avs_write, // Write
  input wire logic [31:0] avs_readdata, // Read data
  input wire logic avs_waitrequest, // Stall
  input wire dur_modem_t [`DUR_NUM_CH-1:0] modemIn, // Modem inputs
  input wire dur_pins_t [`DUR_NUM_CH-1:0] pinsOut // Pins
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic [4:0] idx; // Register index
  logic ch; // Channel
  logic done; // Read answered
  assign idx = avs_address[6:2];
  assign ch = avs_address[7];
  assign done = avs_read && !avs_waitrequest;
  // Reset pin held long enough for pins to follow
  sequence s_held;
    pinReset [*3];
  endsequence
  // Fresh request stalled outside the reset pin
  sequence s_stalled;
    (avs_read || avs_write) && avs_waitrequest && !pinReset ##1 !pinReset;
  endsequence
  a_pins_reset: assert property (s_held |-> pinsOut[0][7:2] == 6'b111110 &&
    pinsOut[1][7:2] == 6'b111110) else $error("pins not at reset levels");
  a_irq_float: assert property (s_held |-> !pinsOut[0].irqOe &&
    !pinsOut[1].irqOe) else $error("interrupt pin driven in reset");
  a_ready_levels: assert property (pinsOut[0][3:2] == 2'b10 &&
    pinsOut[1][3:2] == 2'b10) else $error("ready pins wrong");
  a_wait_one: assert property (s_stalled |-> !avs_waitrequest)
    else $error("answer not after one stall");
  a_pin_stall: assert property (s_held ##0 (avs_read || avs_write) |-> avs_waitrequest)
    else $error("answered under reset pin");
  a_line_stat: assert property (done && idx == 5'h07 |-> avs_readdata == 32'h0000_0060)
    else $error("line status wrong");
  a_modem_upper: assert property (done && idx == 5'h08 && $stable(modemIn) |->
    avs_readdata[7:4] == ~modemIn[ch]) else $error("modem status upper wrong");
  a_unmapped_zero: assert property (done && idx > 5'h14 |-> avs_readdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (done |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
endmodule
bind dur_reset_regs dur_reset_props u_props (.clk_sys(clk_sys), .reset(reset),
  .pinReset(pinReset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .modemIn(modemIn), .pinsOut(pinsOut));
`default_nettype wire

// ### verif/dur_reset_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dur_map.svh"
module dur_reset_regs_bench;
  import dur_pkg::*;
  logic clk_sys = 1'b0; // Clock
  logic reset = 1'b1; // Power-up reset
  logic pinReset = 1'b0; // Reset pin
  logic [7:0] avsAddress; // Bus address
  logic avsRead, avsWrite, avsWait; // Bus strobes
  logic [31:0] avsWdata, avsRdata; // Bus data
  logic [3:0] avsBe; // Lanes
  dur_modem_t [1:0] modemIn = 8'hff; // Modem inputs, idle high
  dur_pins_t [1:0] pinsOut; // Pins
  int failures = 0; // Mismatches
  int n_compared = 0; // Comparisons
  always #5 clk_sys = ~clk_sys;
  dur_host host (.clk_sys(clk_sys), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWdata), .avs_byteenable(avsBe),
    .avs_readdata(avsRdata), .avs_waitrequest(avsWait));
  dur_reset_regs dut (.clk_sys(clk_sys), .reset(reset), .pinReset(pinReset),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_writedata(avsWdata), .avs_byteenable(avsBe), .avs_readdata(avsRdata),
    .avs_waitrequest(avsWait), .modemIn(modemIn), .pinsOut(pinsOut));
  // Byte comparison
  task automatic chk8(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic rd(input logic c, input logic [4:0] i, output logic [7:0] q);
    host.xfer(1'b0, {c, i, 2'b00}, 8'h00, 1'b1, q);
  endtask
  task automatic wr(input logic c, input logic [4:0] i, input logic [7:0] d);
    logic [7:0] q;
    host.xfer(1'b1, {c, i, 2'b00}, d, 1'b1, q);
  endtask
  // Readable value after reset
  function automatic logic [7:0] rst_val(input int i);
    case (i)
      4, 10: return 8'h01;
      7: return 8'h60;
      9: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  // Register set of one channel, indices 1 to 20
  task automatic check_all(input logic c, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] q;
    for (int i = 1; i <= 20; i++) begin
      rd(c, 5'(i), q);
      chk8($sformatf("reg %0d ch %0d", i, c), (i == 10) ? lo : (i == 11) ? hi :
        rst_val(i), q);
    end
  endtask
  task automatic t_power_up();
    check_all(1'b0, 8'h01, 8'h00);
    check_all(1'b1, 8'h01, 8'h00);
    chk8("pins A", 8'hf8, pinsOut[0] & 8'hfd);
    chk8("pins B", 8'hf8, pinsOut[1] & 8'hfd);
    $display("test power_up done");
  endtask
  task automatic t_refused();
    logic [7:0] q;
    wr(1'b0, 5'h0c, 8'h33);
    rd(1'b0, 5'h0c, q);
    chk8("locked fracdiv", 8'h00, q);
    wr(1'b0, 5'h07, 8'h00);
    rd(1'b0, 5'h07, q);
    chk8("line status", 8'h60, q);
    host.xfer(1'b1, 8'h24, 8'h12, 1'b0, q);
    wr(1'b0, 5'h1f, 8'h55);
    rd(1'b0, 5'h1f, q);
    chk8("unmapped", 8'h00, q);
    rd(1'b0, 5'h09, q);
    chk8("masked write", 8'hff, q);
    $display("test refused done");
  endtask
  task automatic t_pin_reset();
    logic [4:0] wl[14] = '{5'h0f, 5'h02, 5'h03, 5'h05, 5'h06, 5'h09, 5'h0a, 5'h0b,
      5'h0c, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};
    logic [7:0] q;
    for (int c = 0; c < 2; c++) begin
      foreach (wl[k]) begin
        wr(c[0], wl[k], (wl[k] == 5'h0f) ? 8'h10 : (wl[k] == 5'h05) ? 8'h40 :
          (wl[k] == 5'h06) ? 8'h0b : (wl[k] == 5'h0b) ? 8'ha5 : 8'h5a);
      end
      rd(c[0], 5'h0c, q);
      chk8("fracdiv set", 8'h5a, q);
    end
    repeat (2) @(posedge clk_sys);
    chk8("pins A run", 8'h09, pinsOut[0] & 8'hfd);
    chk8("pins B run", 8'h09, pinsOut[1] & 8'hfd);
    pinReset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk8("pins A held", 8'hf8, pinsOut[0] & 8'hfd);
    chk8("pins B held", 8'hf8, pinsOut[1] & 8'hfd);
    fork
      rd(1'b1, 5'h09, q);
      begin
        repeat (3) @(posedge clk_sys);
        pinReset <= 1'b0;
      end
    join
    chk8("stalled read", 8'hff, q);
    check_all(1'b0, 8'h5a, 8'ha5);
    check_all(1'b1, 8'h5a, 8'ha5);
    $display("test pin_reset done");
  endtask
  task automatic t_modem();
    logic [7:0] q;
    modemIn <= 8'h5a;
    repeat (2) @(posedge clk_sys);
    rd(1'b0, 5'h08, q);
    chk8("modem A", 8'h50, q & 8'hf0);
    rd(1'b1, 5'h08, q);
    chk8("modem B", 8'ha0, q & 8'hf0);
    $display("test modem done");
  endtask
  // Counts and verdict
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_power_up();
    t_refused();
    t_pin_reset();
    t_modem();
    report_and_stop();
  end
  // Hang guard
  initial begin
    repeat (8000) @(posedge clk_sys);
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire
